/* verilog/snw_pkg.sv */
// Shared constants of the serial nonvolatile RAM write-permit logic.
// Assumes SPI mode 0 or 3, MSB first, one opcode byte per frame.
package snw_pkg;

  // ------------------------------------------------------------------
  // Array geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 9;

  // ------------------------------------------------------------------
  // Opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] OPC_SET_LATCH = 8'h06;
  localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
  localparam logic [7:0] OPC_STAT_READ = 8'h05;
  localparam logic [7:0] OPC_STAT_STORE = 8'h01;
  localparam logic [7:0] OPC_WR_LO = 8'h02;
  localparam logic [7:0] OPC_WR_HI = 8'h0A;
  localparam logic [7:0] OPC_RD_LO = 8'h03;
  localparam logic [7:0] OPC_RD_HI = 8'h0B;
  localparam logic [7:0] OPC_HALF_MASK = 8'hF7;
  localparam int HALF_BIT = 3;

  // ------------------------------------------------------------------
  // Status byte layout
  // ------------------------------------------------------------------
  localparam int PERMIT_BIT = 1;
  localparam int GUARD0_BIT = 2;
  localparam int GUARD1_BIT = 3;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] STAT_USED = 8'h0E;

  // ------------------------------------------------------------------
  // Link framing
  // ------------------------------------------------------------------
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;

endpackage

/* verilog/snw_link_if.sv */
// Byte channel between the SPI clock domain and the system domain.
// Assumes the system side holds tx_byte steady between byte events.
`timescale 1ns/10ps
interface snw_link_if;
  logic byte_tgl;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;

  modport link (output byte_tgl, output rx_byte, input tx_byte);
  modport core (input byte_tgl, input rx_byte, output tx_byte);
endinterface

/* verilog/snw_link.sv */
// SPI shifter running on the host serial clock.
// Assumes the serial clock may stop outside frames; chip select restarts
// the bit count, and the system reset only clears the toggle, the receive holder and the transmit shifter.
`timescale 1ns/10ps
module snw_link
(
  input wire logic i_srst,
  input wire logic i_spi_sck,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe_n,
  snw_link_if.link lnk
);
  logic [2:0] bit_cnt_reg;
  logic [6:0] rx_sh_reg;
  logic [7:0] rx_hold_reg;
  logic tgl_reg;
  logic [7:0] tx_sh_reg;

  // ------------------------------------------------------------------
  // Receive side
  // ------------------------------------------------------------------

  // Bit position, restarted by every deselect
  always_ff @(posedge i_spi_sck or posedge i_spi_cs_n)
  begin
    if (i_spi_cs_n)
      bit_cnt_reg <= snw_pkg::BIT_FIRST;
    else
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
  end

  // Serial input, MSB first
  always_ff @(posedge i_spi_sck)
  begin
    rx_sh_reg <= {rx_sh_reg[5:0], i_spi_mosi};
  end

  // Whole byte held and announced by a toggle
  always_ff @(posedge i_spi_sck or posedge i_srst)
  begin
    if (i_srst)
    begin
      tgl_reg <= 1'b0;
      rx_hold_reg <= 8'h00;
    end
    else if (bit_cnt_reg == snw_pkg::BIT_LAST)
    begin
      tgl_reg <= ~tgl_reg;
      rx_hold_reg <= {rx_sh_reg, i_spi_mosi};
    end
  end

  assign lnk.byte_tgl = tgl_reg;
  assign lnk.rx_byte = rx_hold_reg;

  // ------------------------------------------------------------------
  // Transmit side
  // ------------------------------------------------------------------

  // Loads at a byte boundary, shifts on falling edges
  always_ff @(negedge i_spi_sck or posedge i_srst)
  begin
    if (i_srst)
      tx_sh_reg <= 8'h00;
    else if (bit_cnt_reg == snw_pkg::BIT_FIRST)
      tx_sh_reg <= lnk.tx_byte;
    else
      tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
  end

  assign o_spi_miso = tx_sh_reg[7];
  assign o_spi_miso_oe_n = i_spi_cs_n; // Driven only while selected

endmodule // snw_link

/* verilog/snw_top.sv */
// Command interpreter and write-permit latch of a 512-byte SPI RAM.
// Assumes the host keeps the serial clock at most an eighth of the
// system clock, so a byte crosses before its reply bit is shifted out.
// How it works
// RQ1: The set-latch opcode sets the write-permit latch.
// RQ2: Status bit 1 shows the latch, and 1 means writes are allowed.
// RQ3: A status store never changes the latch bit itself.
// RQ4: A finished memory or status write clears the latch at deselect.
// RQ5: A write using the upper-half opcode 0x0A leaves the latch set.
// RQ6: The host waits 1 ms after power-up before the first select; the bench host waits 2000 ns.
// RQ7: Opcode bit 3 carries address bit 8 (0x02/0x0A write, 0x03/0x0B read).
// RQ8: The latch clears at reset; status bits 0 and 4 to 7 read as zero.
// RQ9: The clear-latch opcode clears the latch and blocks all writes.
// RQ10: The host may send the clear-latch opcode after every write.
// RQ11: A write arriving while the latch is clear changes nothing.
`timescale 1ns/10ps
module snw_top
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_spi_sck,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe_n,
  output logic o_write_permit,
  output logic [1:0] o_region_guard
);
  localparam int AW = snw_pkg::ADDR_W;
  localparam int DEPTH = 1 << AW;

  typedef enum logic [2:0] {
    ST_OPC, ST_ADDR, ST_WR, ST_RD, ST_STAT, ST_SKIP
  } snw_state_t;

  snw_link_if lnk_if ();

  snw_state_t state_reg;
  logic [7:0] opc_reg;
  logic [AW-1:0] addr_reg;
  logic [AW-1:0] addr_inc;
  logic [AW-1:0] addr_first;
  logic permit_reg;
  logic clr_due_reg;
  logic [1:0] guard_reg;
  logic [7:0] tx_reg;
  logic [7:0] status;
  logic [7:0] mem [DEPTH];
  logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic byte_evt;
  logic frame_end;
  logic [7:0] rx;
  logic rx_mem_wr;
  logic rx_mem_rd;

  // ------------------------------------------------------------------
  // Link side and crossing
  // ------------------------------------------------------------------
  snw_link u_link
  (
    .i_srst(i_srst),
    .i_spi_sck(i_spi_sck),
    .i_spi_cs_n(i_spi_cs_n),
    .i_spi_mosi(i_spi_mosi),
    .o_spi_miso(o_spi_miso),
    .o_spi_miso_oe_n(o_spi_miso_oe_n),
    .lnk(lnk_if.link)
  );

  // Two-stage synchronisers plus an edge stage
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      {tgl_s1_reg, tgl_s2_reg, tgl_s3_reg} <= 3'h0;
      {cs_s1_reg, cs_s2_reg, cs_s3_reg} <= 3'h7;
    end
    else
    begin
      {tgl_s1_reg, tgl_s2_reg, tgl_s3_reg} <=
        {lnk_if.byte_tgl, tgl_s1_reg, tgl_s2_reg};
      {cs_s1_reg, cs_s2_reg, cs_s3_reg} <=
        {i_spi_cs_n, cs_s1_reg, cs_s2_reg};
    end
  end

  // Byte arrival, deselect, opcode decode
  assign byte_evt = tgl_s2_reg ^ tgl_s3_reg;
  assign frame_end = cs_s2_reg & ~cs_s3_reg;
  assign rx = lnk_if.rx_byte;
  assign rx_mem_wr = (rx & snw_pkg::OPC_HALF_MASK) == snw_pkg::OPC_WR_LO;
  assign rx_mem_rd = (rx & snw_pkg::OPC_HALF_MASK) == snw_pkg::OPC_RD_LO;
  assign addr_inc = addr_reg + {{(AW-1){1'b0}}, 1'b1};
  assign addr_first = {opc_reg[snw_pkg::HALF_BIT], rx}; // [RQ7]
  assign lnk_if.tx_byte = tx_reg;

  // Status byte, unused bits held at zero
  always_comb
  begin
    status = snw_pkg::STAT_RESET; // [RQ8]
    status[snw_pkg::PERMIT_BIT] = permit_reg; // [RQ2]
    status[snw_pkg::GUARD0_BIT] = guard_reg[0];
    status[snw_pkg::GUARD1_BIT] = guard_reg[1];
  end

  // ------------------------------------------------------------------
  // Command sequencing
  // ------------------------------------------------------------------

  // Frame phase
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || frame_end)
      state_reg <= ST_OPC;
    else if (byte_evt)
    begin
      case (state_reg)
        ST_OPC:
        begin
          if (rx_mem_wr)
            state_reg <= permit_reg ? ST_ADDR : ST_SKIP; // [RQ11]
          else if (rx_mem_rd)
            state_reg <= ST_ADDR;
          else if (rx == snw_pkg::OPC_STAT_STORE)
            state_reg <= permit_reg ? ST_STAT : ST_SKIP; // [RQ11]
          else
            state_reg <= ST_SKIP;
        end
        ST_ADDR:
          state_reg <= (opc_reg[0] == 1'b0) ? ST_WR : ST_RD;
        ST_STAT:
          state_reg <= ST_SKIP;
        default:
          state_reg <= state_reg;
      endcase
    end
  end

  // Opcode of the current frame
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      opc_reg <= 8'h00;
    else if (byte_evt && state_reg == ST_OPC)
      opc_reg <= rx;
  end

  // Address with auto-increment
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      addr_reg <= '0;
    else if (byte_evt && state_reg == ST_ADDR)
      addr_reg <= addr_first; // [RQ7]
    else if (byte_evt && (state_reg == ST_WR || state_reg == ST_RD))
      addr_reg <= addr_inc;
  end

  // Array store
  always_ff @(posedge i_sys_clk)
  begin
    if (byte_evt && state_reg == ST_WR)
      mem[addr_reg] <= rx;
  end

  // Reply byte for the next shift-out
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      tx_reg <= 8'h00;
    else if (byte_evt && (state_reg == ST_OPC || state_reg == ST_SKIP)
             && (state_reg == ST_SKIP ? opc_reg : rx)
                == snw_pkg::OPC_STAT_READ)
      tx_reg <= status; // [RQ2]
    else if (byte_evt && state_reg == ST_ADDR)
      tx_reg <= mem[addr_first];
    else if (byte_evt && state_reg == ST_RD)
      tx_reg <= mem[addr_inc];
  end

  // ------------------------------------------------------------------
  // Write-permit latch and region guard bits
  // ------------------------------------------------------------------

  // Armed by a permitted write, except upper-half memory writes
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || frame_end)
      clr_due_reg <= 1'b0;
    else if (byte_evt && (state_reg == ST_STAT ||
             (state_reg == ST_WR && opc_reg != snw_pkg::OPC_WR_HI)))
      clr_due_reg <= 1'b1; // [RQ4] [RQ5]
  end

  // Latch: cleared at reset, set or cleared by its own opcodes
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      permit_reg <= 1'b0; // [RQ8]
    else if (frame_end && clr_due_reg)
      permit_reg <= 1'b0; // [RQ4]
    else if (byte_evt && state_reg == ST_OPC &&
             rx == snw_pkg::OPC_SET_LATCH)
      permit_reg <= 1'b1; // [RQ1]
    else if (byte_evt && state_reg == ST_OPC &&
             rx == snw_pkg::OPC_CLR_LATCH)
      permit_reg <= 1'b0; // [RQ9]
  end

  // Status store touches only the guard bits
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      guard_reg <= 2'h0;
    else if (byte_evt && state_reg == ST_STAT)
      guard_reg <= {rx[snw_pkg::GUARD1_BIT], rx[snw_pkg::GUARD0_BIT]}; // [RQ3]
  end

  assign o_write_permit = permit_reg;
  assign o_region_guard = guard_reg;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  AST_SET_ON_ENABLE: assert property ( // [RQ1]
    byte_evt && state_reg == ST_OPC && rx == snw_pkg::OPC_SET_LATCH
    |=> permit_reg ##1 (permit_reg || frame_end))
    else $error("latch not set by enable opcode");

  AST_FLAG_SHOWS_LATCH: assert property ( // [RQ2]
    byte_evt && state_reg == ST_OPC && rx == snw_pkg::OPC_STAT_READ
    |=> tx_reg[snw_pkg::PERMIT_BIT] == $past(permit_reg))
    else $error("status reply does not show the latch");

  AST_STORE_KEEPS_LATCH: assert property ( // [RQ3]
    byte_evt && state_reg == ST_STAT |=> $stable(permit_reg))
    else $error("status store changed the latch");

  AST_DONE_CLEARS: assert property ( // [RQ4]
    frame_end && clr_due_reg |=> !permit_reg && state_reg == ST_OPC)
    else $error("latch still set after a finished write");

  AST_UPPER_KEEPS: assert property ( // [RQ5]
    state_reg == ST_WR && opc_reg == snw_pkg::OPC_WR_HI |-> !clr_due_reg)
    else $error("upper-half write armed the latch clear");

  AST_HALF_FROM_OPCODE: assert property ( // [RQ7]
    byte_evt && state_reg == ST_ADDR
    |=> addr_reg[AW-1] == $past(opc_reg[snw_pkg::HALF_BIT]))
    else $error("address bit 8 not taken from opcode");

  AST_UNUSED_ZERO: assert property ( // [RQ8]
    byte_evt && state_reg == ST_OPC && rx == snw_pkg::OPC_STAT_READ
    |=> (tx_reg & ~snw_pkg::STAT_USED) == 8'h00)
    else $error("unused status bits not zero");

  AST_DISABLE_CLEARS: assert property ( // [RQ9]
    byte_evt && state_reg == ST_OPC && rx == snw_pkg::OPC_CLR_LATCH
    |=> !permit_reg)
    else $error("latch not cleared by disable opcode");

  AST_LOCKED_SKIPS: assert property ( // [RQ11]
    byte_evt && state_reg == ST_OPC && !permit_reg &&
    (rx_mem_wr || rx == snw_pkg::OPC_STAT_STORE)
    |=> state_reg == ST_SKIP ##1 $stable(guard_reg))
    else $error("write accepted while the latch was clear");

endmodule // snw_top

/* test/snw_host_model.sv */
// SPI host model that drives chip select, serial clock and data.
// Assumes mode 0 and a 64 ns serial clock that runs only inside frames.
`timescale 1ns/10ps
module snw_host
#(
  parameter int PU_WAIT_NS = 1000000
)
(
  output logic o_sck,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso,
  input wire logic i_miso_oe_n
);
  bit pu_done;

  // ------------------------------------------------------------------
  // Power-up
  // ------------------------------------------------------------------
  // Idle lines, then hold off the first select
  initial
  begin
    o_sck = 1'b0;
    o_cs_n <= 1'b1; // Late in time zero so the bit count sees an edge
    o_mosi = 1'b0;
    pu_done = 1'b0;
    #(PU_WAIT_NS); // Supply settle before first select
    pu_done = 1'b1;
  end

  // ------------------------------------------------------------------
  // Frame
  // ------------------------------------------------------------------
  // Shifts n bytes from the top of tx, MSB first, and captures miso
  task automatic frame(input int n, input logic [31:0] tx,
                       output logic [31:0] rx);
    rx = 32'h0;
    for (int k = 0; k < PU_WAIT_NS / 10 + 2 && !pu_done; k++)
      #10; // Bounded hold-off for first access
    #1.37; // Phase unrelated to the system clock
    o_cs_n = 1'b0;
    for (int i = 0; i < n * 8; i++)
    begin
      o_mosi = tx[31 - i];
      #32;
      o_sck = 1'b1;
      rx[31 - i] = i_miso_oe_n ? ~i_miso : i_miso;
      #32;
      o_sck = 1'b0;
    end
    #20;
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // Released line shows no stale value
    #100; // Deselect time
  endtask
endmodule // snw_host

/* test/tb.sv */
// Self-checking bench of the write-permit latch logic.
// Assumes the host model in snw_host_model.sv and the snw_pkg constants.
`timescale 1ns/10ps
module tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b0;
  logic spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
  logic write_permit;
  logic [1:0] region_guard;
  logic [31:0] rx, rnd;
  int mismatches = 0;
  int n_tests = 0;
  int seed = 57;

  // System clock, 4 ns period
  always #2 sys_clk = ~sys_clk;

  snw_top i_dut (.i_sys_clk(sys_clk), .i_srst(srst), .i_spi_sck(spi_sck),
    .i_spi_cs_n(spi_cs_n), .i_spi_mosi(spi_mosi), .o_spi_miso(spi_miso),
    .o_spi_miso_oe_n(spi_miso_oe_n), .o_write_permit(write_permit),
    .o_region_guard(region_guard));

  snw_host #(.PU_WAIT_NS(2000)) i_host (.o_sck(spi_sck),
    .o_cs_n(spi_cs_n), .o_mosi(spi_mosi), .i_miso(spi_miso),
    .i_miso_oe_n(spi_miso_oe_n));

  // ------------------------------------------------------------------
  // Expectations and helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] stat_exp(input logic [1:0] gd,
                                          input logic wp);
    return {4'h0, gd, wp, 1'h0};
  endfunction

  function automatic logic [7:0] mem_op(input logic rd, input logic hi);
    return (rd ? snw_pkg::OPC_RD_LO : snw_pkg::OPC_WR_LO) | {4'h0, hi, 3'h0};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (mismatches == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmd(input int n, input logic [31:0] tx);
    i_host.frame(n, tx, rx);
  endtask

  // Status read plus pin check
  task automatic stat(input logic [1:0] gd, input logic wp);
    cmd(2, {snw_pkg::OPC_STAT_READ, 24'h0});
    chk(rx[23:16], stat_exp(gd, wp));
    chk({6'h0, region_guard}, {6'h0, gd});
    chk({7'h0, write_permit}, {7'h0, wp});
  endtask

  task automatic wr(input logic hi, input logic [7:0] a, input logic [7:0] d);
    cmd(3, {mem_op(1'h0, hi), a, d, 8'h00});
  endtask

  task automatic rd_chk(input logic hi, input logic [7:0] a,
                        input logic [7:0] exp);
    cmd(3, {mem_op(1'h1, hi), a, 16'h0});
    chk(rx[15:8], exp);
  endtask

  task automatic set_l();
    cmd(1, {snw_pkg::OPC_SET_LATCH, 24'h0});
  endtask

  task automatic clr_l();
    cmd(1, {snw_pkg::OPC_CLR_LATCH, 24'h0});
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  // Reset, directed corner cases, then random writes
  initial
  begin
    srst <= 1'b1; // Late in time zero so the link clear sees an edge
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    repeat (4) @(negedge sys_clk);
    stat(2'h0, 1'h0);
    set_l();
    stat(2'h0, 1'h1);
    wr(1'h0, 8'h5A, 8'hC3);
    stat(2'h0, 1'h0);
    rd_chk(1'h0, 8'h5A, 8'hC3);
    wr(1'h0, 8'h5A, 8'h3C);
    cmd(2, {snw_pkg::OPC_STAT_STORE, 8'hFF, 16'h0});
    stat(2'h0, 1'h0);
    rd_chk(1'h0, 8'h5A, 8'hC3);
    set_l();
    cmd(2, {snw_pkg::OPC_STAT_STORE, 8'hF5, 16'h0});
    stat(2'h1, 1'h0);
    set_l();
    cmd(2, {snw_pkg::OPC_STAT_STORE, 8'h0A, 16'h0});
    stat(2'h2, 1'h0);
    set_l();
    wr(1'h1, 8'h11, 8'hA5);
    stat(2'h2, 1'h1);
    wr(1'h1, 8'h12, 8'h96);
    rd_chk(1'h1, 8'h11, 8'hA5);
    rd_chk(1'h1, 8'h12, 8'h96);
    clr_l();
    stat(2'h2, 1'h0);
    wr(1'h1, 8'h11, 8'h00);
    rd_chk(1'h1, 8'h11, 8'hA5);
    // Random address and data in both halves
    for (int i = 0; i < 8; i++)
    begin
      rnd = $random(seed);
      set_l();
      wr(rnd[8], rnd[7:0], rnd[16:9]);
      chk({7'h0, write_permit}, {7'h0, rnd[8]});
      rd_chk(rnd[8], rnd[7:0], rnd[16:9]);
      clr_l();
      chk({7'h0, write_permit}, 8'h00);
    end
    test_done();
  end

  // Watchdog against a hung run
  initial
  begin
    #300000;
    mismatches++;
    test_done();
  end
endmodule // tb
